//--- hdl/cps_cursor_split.v
`timescale 1ns/100ps
`default_nettype none
`include "cps_map.vh"

module cps_cursor_split (
	// clock and reset
	input  wire                      ref_clk,
	input  wire                      sys_rst,
	// apb slave
	input  wire                      psel,
	input  wire                      penable,
	input  wire                      pwrite,
	input  wire [`CPS_ADDR_W-1:0]    paddr,
	input  wire [31:0]               pwdata,
	output reg                       pready,
	output reg  [31:0]               prdata,
	output reg                       pslverr,
	// raster timing from the pixel side
	input  wire                      frameStart,
	input  wire                      lineStart,
	input  wire [`CPS_COORD_W-1:0]   scanLineCount,
	input  wire [`CPS_COORD_W-1:0]   pixelCount,
	// general configuration bits
	input  wire                      cursorEnable,
	input  wire                      splitCompareEnable,
	input  wire                      startOffsetCompareEnable,
	// cursor overlay
	output reg  [`CPS_COORD_W-1:0]   liveCursorCol_q,
	output reg  [`CPS_ROW_W-1:0]     liveCursorRow_q,
	output reg  [`CPS_PAT_W-1:0]     liveColOffset_q,
	output reg  [`CPS_PAT_W-1:0]     liveRowOffset_q,
	output reg                       cursorHit_q,
	output reg  [`CPS_PAT_W-1:0]     patternCol_q,
	output reg  [`CPS_PAT_W-1:0]     patternRow_q,
	// frame-buffer fetch
	output reg                       fetchAddrReset_q,
	output reg                       startOffsetLoad_q
);

	// software-written shadow copies
	reg  [`CPS_COORD_W-1:0] cursorCol_q;
	reg  [`CPS_PAT_W-1:0]   colOffset_q;
	reg  [`CPS_ROW_W-1:0]   cursorRow_q;
	reg  [`CPS_PAT_W-1:0]   rowOffset_q;
	reg  [`CPS_COORD_W-1:0] splitLineValue_q;

	wire                    access;
	wire                    wrDone;
	wire                    hitCol;
	wire                    hitScan;
	wire                    hitRow;
	wire                    hitSplit;
	wire                    mapped;
	wire                    hitNow;
	wire [`CPS_PAT_W-1:0]   patColNow;
	wire [`CPS_PAT_W-1:0]   patRowNow;
	wire                    splitMatch;
	wire                    startMatch;
	reg  [31:0]             rdData;

	// every transfer takes one wait state so read data can come from a flop
	assign access   = psel && penable;
	assign wrDone   = access && pready && pwrite;
	assign hitCol   = (paddr == `CPS_OFS_CURSOR_COL);
	assign hitScan  = (paddr == `CPS_OFS_SCAN_LINE);
	assign hitRow   = (paddr == `CPS_OFS_CURSOR_ROW);
	assign hitSplit = (paddr == `CPS_OFS_SPLIT_CMP);
	assign mapped   = hitCol || hitScan || hitRow || hitSplit;

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `CPS_RST_DATA;
		end else begin
			pready  <= access && !pready;
			pslverr <= access && !pready && !mapped;
			if (access && !pready && !pwrite) begin
				prdata <= rdData;
			end
		end
	end

	always @* begin
		rdData = `CPS_RST_DATA;
		if (hitCol) begin
			rdData[`CPS_OFFSET_HI:`CPS_OFFSET_LO] = colOffset_q;
			rdData[`CPS_COL_HI:0]                 = cursorCol_q;
		end else if (hitScan) begin
			// taken straight from the raster counter: may be caught mid-change
			rdData[`CPS_LINE_HI:0] = scanLineCount;
		end else if (hitRow) begin
			rdData[`CPS_OFFSET_HI:`CPS_OFFSET_LO] = rowOffset_q;
			rdData[`CPS_ROW_HI:0]                 = cursorRow_q;
		end else if (hitSplit) begin
			rdData[`CPS_LINE_HI:0] = splitLineValue_q;
		end
	end

	// register writes; reserved bits are dropped
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			cursorCol_q      <= `CPS_RST_COORD;
			colOffset_q      <= `CPS_RST_OFS;
			cursorRow_q      <= `CPS_RST_ROW;
			rowOffset_q      <= `CPS_RST_OFS;
			splitLineValue_q <= `CPS_RST_COORD;
		end else if (wrDone) begin
			if (hitCol) begin
				colOffset_q <= pwdata[`CPS_OFFSET_HI:`CPS_OFFSET_LO];
				cursorCol_q <= pwdata[`CPS_COL_HI:0];
			end
			if (hitRow) begin
				rowOffset_q <= pwdata[`CPS_OFFSET_HI:`CPS_OFFSET_LO];
				cursorRow_q <= pwdata[`CPS_ROW_HI:0];
			end
			if (hitSplit) begin
				splitLineValue_q <= pwdata[`CPS_LINE_HI:0];
			end
		end
	end

	// latch into the overlay only at frame start to avoid tearing
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			liveCursorCol_q <= `CPS_RST_COORD;
			liveCursorRow_q <= `CPS_RST_ROW;
			liveColOffset_q <= `CPS_RST_OFS;
			liveRowOffset_q <= `CPS_RST_OFS;
		end else if (frameStart) begin
			liveCursorCol_q <= cursorCol_q;
			liveCursorRow_q <= cursorRow_q;
			liveColOffset_q <= colOffset_q;
			liveRowOffset_q <= rowOffset_q;
		end
	end

	cps_cursor_window u_window (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.lineStart    (lineStart),
		.lineCount    (scanLineCount),
		.pixelCount   (pixelCount),
		.cursorEnable (cursorEnable),
		.cursorCol    (liveCursorCol_q),
		.cursorRow    (liveCursorRow_q),
		.colOffset    (liveColOffset_q),
		.rowOffset    (liveRowOffset_q),
		.cursorHit    (hitNow),
		.patternCol   (patColNow),
		.patternRow   (patRowNow)
	);

	cps_line_compare u_split (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.lineStart  (lineStart),
		.lineCount  (scanLineCount),
		.cmpEnable  (splitCompareEnable),
		.cmpValue   (splitLineValue_q),
		.matchPulse (splitMatch)
	);

	// row field reused as compare; uses the written value, not the frame copy,
	// since a legacy program expects it to act within the current frame
	cps_line_compare u_start (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.lineStart  (lineStart),
		.lineCount  (scanLineCount),
		.cmpEnable  (startOffsetCompareEnable),
		.cmpValue   ({1'b0, cursorRow_q}),
		.matchPulse (startMatch)
	);

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			cursorHit_q       <= 1'b0;
			patternCol_q      <= `CPS_RST_OFS;
			patternRow_q      <= `CPS_RST_OFS;
			fetchAddrReset_q  <= 1'b0;
			startOffsetLoad_q <= 1'b0;
		end else begin
			cursorHit_q       <= hitNow;
			patternCol_q      <= patColNow;
			patternRow_q      <= patRowNow;
			fetchAddrReset_q  <= splitMatch;
			startOffsetLoad_q <= startMatch;
		end
	end

endmodule
`default_nettype wire

//--- hdl/cps_map.vh
`ifndef CPS_MAP_VH
`define CPS_MAP_VH

// register byte offsets
`define CPS_ADDR_W          16
`define CPS_OFS_CURSOR_COL  16'h8350
`define CPS_OFS_SCAN_LINE   16'h8354
`define CPS_OFS_CURSOR_ROW  16'h8358
`define CPS_OFS_SPLIT_CMP   16'h835C

// field positions
`define CPS_OFFSET_HI       15
`define CPS_OFFSET_LO       11
`define CPS_COL_HI          10
`define CPS_ROW_HI          9
`define CPS_LINE_HI         10

// widths
`define CPS_PAT_SIZE        6'h20
`define CPS_PAT_W           5
`define CPS_COORD_W         11
`define CPS_ROW_W           10

// reset values of control state
`define CPS_RST_COORD       11'h000
`define CPS_RST_ROW         10'h000
`define CPS_RST_OFS         5'h00
`define CPS_RST_DATA        32'h0000_0000

`endif

//--- hdl/cps_line_compare.v
`timescale 1ns/100ps
`default_nettype none
`include "cps_map.vh"

module cps_line_compare (
	// clock and reset
	input  wire                      ref_clk,
	input  wire                      sys_rst,
	// line timing
	input  wire                      lineStart,
	input  wire [`CPS_COORD_W-1:0]   lineCount,
	// compare setup
	input  wire                      cmpEnable,
	input  wire [`CPS_COORD_W-1:0]   cmpValue,
	// result
	output reg                       matchPulse
);

	// one look per line so a value written mid-line cannot fire twice
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			matchPulse <= 1'b0;
		end else begin
			matchPulse <= lineStart && cmpEnable && (lineCount == cmpValue);
		end
	end

endmodule
`default_nettype wire

//--- hdl/cps_cursor_window.v
`timescale 1ns/100ps
`default_nettype none
`include "cps_map.vh"

module cps_cursor_window (
	// clock and reset
	input  wire                      ref_clk,
	input  wire                      sys_rst,
	// raster position
	input  wire                      lineStart,
	input  wire [`CPS_COORD_W-1:0]   lineCount,
	input  wire [`CPS_COORD_W-1:0]   pixelCount,
	// cursor enable and frame-latched cursor setup
	input  wire                      cursorEnable,
	input  wire [`CPS_COORD_W-1:0]   cursorCol,
	input  wire [`CPS_ROW_W-1:0]     cursorRow,
	input  wire [`CPS_PAT_W-1:0]     colOffset,
	input  wire [`CPS_PAT_W-1:0]     rowOffset,
	// overlay outputs
	output reg                       cursorHit,
	output reg  [`CPS_PAT_W-1:0]     patternCol,
	output reg  [`CPS_PAT_W-1:0]     patternRow
);

	reg                   rowHit_q;
	wire [11:0]           lineDiff;
	wire [11:0]           pixDiff;
	wire [5:0]            rowSpan;
	wire [5:0]            colSpan;

	assign lineDiff = {1'b0, lineCount} - {2'b00, cursorRow};
	assign pixDiff  = {1'b0, pixelCount} - {1'b0, cursorCol};
	// pattern rows/columns ahead of the offset are skipped, shrinking the shown span
	assign rowSpan  = `CPS_PAT_SIZE - {1'b0, rowOffset};
	assign colSpan  = `CPS_PAT_SIZE - {1'b0, colOffset};

	// row decision is made once per line from the live vertical counter
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			rowHit_q   <= 1'b0;
			patternRow <= `CPS_RST_OFS;
		end else if (lineStart) begin
			rowHit_q   <= cursorEnable && !lineDiff[11] && (lineDiff < {6'h00, rowSpan});
			patternRow <= lineDiff[`CPS_PAT_W-1:0] + rowOffset;
		end
	end

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			cursorHit  <= 1'b0;
			patternCol <= `CPS_RST_OFS;
		end else begin
			cursorHit  <= rowHit_q && !pixDiff[11] && (pixDiff < {6'h00, colSpan});
			patternCol <= pixDiff[`CPS_PAT_W-1:0] + colOffset;
		end
	end

endmodule
`default_nettype wire

//--- verif/cps_cursor_split_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "cps_map.vh"
module cps_props (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// register bus
	input wire logic        pwrite,
	input wire logic [15:0] paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// raster and config
	input wire logic        frameStart,
	input wire logic        lineStart,
	input wire logic        splitCompareEnable,
	input wire logic        startOffsetCompareEnable,
	// watched outputs
	input wire logic [10:0] liveCursorCol_q,
	input wire logic [9:0]  liveCursorRow_q,
	input wire logic [4:0]  liveColOffset_q,
	input wire logic [4:0]  liveRowOffset_q,
	input wire logic        cursorHit_q,
	input wire logic [4:0]  patternCol_q,
	input wire logic [4:0]  patternRow_q,
	input wire logic        fetchAddrReset_q,
	input wire logic        startOffsetLoad_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	AST_COL_HOLD: assert property (
		!frameStart |=> $stable({liveColOffset_q, liveCursorCol_q}))
		else $error("column setup moved mid frame");
	AST_ROW_HOLD: assert property (
		!frameStart |=> $stable({liveRowOffset_q, liveCursorRow_q}))
		else $error("row setup moved mid frame");
	AST_FETCH_LINE: assert property (
		fetchAddrReset_q |-> $past(lineStart, 2))
		else $error("fetch reset without line start");
	AST_FETCH_EN: assert property (
		fetchAddrReset_q |-> $past(splitCompareEnable, 2))
		else $error("fetch reset while split disabled");
	AST_FETCH_PULSE: assert property (
		fetchAddrReset_q |=> !fetchAddrReset_q)
		else $error("fetch reset longer than one cycle");
	AST_LOAD_CAUSE: assert property (
		startOffsetLoad_q |-> $past(lineStart, 2) && $past(startOffsetCompareEnable, 2))
		else $error("start offset load without cause");
	AST_SCAN_RSVD: assert property (
		pready && !pwrite && !pslverr && paddr == `CPS_OFS_SCAN_LINE |-> prdata[31:11] == 21'h0)
		else $error("scan line upper bits not zero");
	AST_PAT_COL: assert property (
		cursorHit_q |-> patternCol_q >= $past(liveColOffset_q, 2))
		else $error("pattern column left of offset");
	AST_PAT_ROW: assert property (
		cursorHit_q |-> patternRow_q >= liveRowOffset_q)
		else $error("pattern row above offset");
endmodule
bind cps_cursor_split cps_props cps_props_inst (.*);
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "cps_map.vh"
module tb;
	logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, frameStart = 0;
	logic lineStart = 0, cursorEnable = 0, splitCompareEnable = 0, startOffsetCompareEnable = 0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, perr, cursorHit_q, fetchAddrReset_q, startOffsetLoad_q;
	logic [10:0] scanLineCount = 11'h000, pixelCount = 11'h000, liveCursorCol_q;
	logic [9:0] liveCursorRow_q;
	logic [4:0] liveColOffset_q, liveRowOffset_q, patternCol_q, patternRow_q;
	int err_count = 0, checks_done = 0, nf, ns;
	always #50 ref_clk = ~ref_clk;
	cps_cursor_split cps_cursor_split_inst (.*);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until pready is seen at an edge; a hang is left to the watchdog
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task line(input logic [10:0] v);
		@(posedge ref_clk);
		scanLineCount <= v;
		lineStart <= 1;
		@(posedge ref_clk);
		lineStart <= 0;
		nf = 0;
		ns = 0;
		repeat (4) begin
			@(posedge ref_clk);
			nf += fetchAddrReset_q;
			ns += startOffsetLoad_q;
		end
	endtask
	task px(input logic [10:0] p, input logic h, input logic [4:0] c);
		pixelCount <= p;
		repeat (4) @(posedge ref_clk);
		chk({31'h0, cursorHit_q}, {31'h0, h});
		if (h) chk({22'h0, patternCol_q, patternRow_q}, {22'h0, c, 5'h02});
	endtask
	task regs;
		apb(1, `CPS_OFS_CURSOR_COL, 32'hFFFF_FFFF);
		apb(1, `CPS_OFS_CURSOR_ROW, 32'hFFFF_FFFF);
		apb(1, `CPS_OFS_SPLIT_CMP, 32'hFFFF_FFFF);
		apb(1, `CPS_OFS_SCAN_LINE, 32'hFFFF_FFFF);
		scanLineCount <= 11'h5A5;
		apb(0, `CPS_OFS_CURSOR_COL, 32'h0000_0000);
		chk(rd, 32'h0000_FFFF);
		apb(0, `CPS_OFS_CURSOR_ROW, 32'h0000_0000);
		chk(rd, 32'h0000_FBFF);
		apb(0, `CPS_OFS_SPLIT_CMP, 32'h0000_0000);
		chk(rd, 32'h0000_07FF);
		apb(0, `CPS_OFS_SCAN_LINE, 32'h0000_0000);
		chk(rd, 32'h0000_05A5);
		apb(0, `CPS_OFS_SCAN_LINE, 32'h0000_0000);
		chk(rd, 32'h0000_05A5);
		apb(0, 16'h8360, 32'h0000_0000);
		chk({perr, rd[30:0]}, 32'h8000_0000);
	endtask
	task frame;
		apb(1, `CPS_OFS_CURSOR_COL, 32'h0000_1864);
		apb(1, `CPS_OFS_CURSOR_ROW, 32'h0000_1050); // pattern base is set outside
		chk({21'h0, liveCursorCol_q}, 32'h0000_0000);
		@(posedge ref_clk);
		frameStart <= 1;
		@(posedge ref_clk);
		frameStart <= 0;
		@(posedge ref_clk);
		chk({1'b0, liveColOffset_q, liveCursorCol_q, liveRowOffset_q, liveCursorRow_q},
			{1'b0, 5'h03, 11'h064, 5'h02, 10'h050});
	endtask
	task split;
		apb(1, `CPS_OFS_SPLIT_CMP, 32'h0000_0123);
		splitCompareEnable <= 1;
		line(11'h123);
		chk(nf, 1);
		line(11'h122);
		chk(nf, 0);
		splitCompareEnable <= 0;
		line(11'h123);
		chk(nf, 0);
		startOffsetCompareEnable <= 1; // cursor stays disabled meanwhile
		line(11'h050);
		chk(ns, 1);
		line(11'h051);
		chk(ns, 0);
		startOffsetCompareEnable <= 0;
	endtask
	task hit;
		cursorEnable <= 1;
		line(11'h050);
		px(11'h063, 0, 5'h00);
		px(11'h064, 1, 5'h03);
		px(11'h080, 1, 5'h1F);
		px(11'h081, 0, 5'h00);
		line(11'h04F);
		px(11'h064, 0, 5'h00);
	endtask
	task conclude;
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		sys_rst <= 0;
		regs();
		frame();
		split();
		hit();
		conclude();
	end
	// tests need well under 1000 cycles
	initial begin
		#300_000;
		err_count++;
		conclude();
	end
endmodule
`default_nettype wire
